/* verilog/sajc_control.v */
// Operator control: function dispatch, alarm history, password protection and jog
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "sajc_defs.vh"

module sajc_control #(
   parameter HOLD_CYCLES = (`SAJC_CLK_HZ / 1000) * `SAJC_HOLD_MS
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        servo_on_input,
   input  wire        key_up,
   input  wire        key_down,
   input  wire        key_data_shift,
   input  wire        servo_toggle_key,
   input  wire        handheld_display_key,
   input  wire        handheld_enter_key,
   input  wire        alarm_valid,
   input  wire [7:0]  alarm_code,
   input  wire        alarm_from_operator,
   input  wire        alarm_reset,
   output reg         alarm_active,
   output reg         motor_power,
   output reg         motor_fwd,
   output reg         motor_rev,
   output reg  [15:0] jog_speed,
   output reg         protect_flash,
   output reg         menu_active,
   output wire        irq
);

   localparam S_MENU = 3'b001;
   localparam S_HIST = 3'b010;
   localparam S_JOG  = 3'b100;
   localparam [31:0] HOLD_LIM = HOLD_CYCLES - 1;

   // Pin synchronisers, one per key/level
   wire [6:0] pin_raw = {servo_on_input, key_up, key_down, key_data_shift,
                         servo_toggle_key, handheld_display_key, handheld_enter_key};
   reg  [6:0] sync1_q;
   reg  [6:0] sync2_q;
   reg  [6:0] prev_q;
   wire [6:0] rise = sync2_q & ~prev_q;
   wire son_s  = sync2_q[6];
   wire up_s   = sync2_q[5];
   wire dn_s   = sync2_q[4];
   wire ds_s   = sync2_q[3];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
         prev_q  <= 7'h00;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // One second hold detect on data-shift: one pulse per hold
   reg [31:0] hold_cnt_q;
   reg        hold_done_q;
   wire       long_ds = ds_s && !hold_done_q && (hold_cnt_q == HOLD_LIM);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt_q  <= 32'h0;
         hold_done_q <= 1'b0;
      end else if (!ds_s) begin
         hold_cnt_q  <= 32'h0;
         hold_done_q <= 1'b0;
      end else if (long_ds) begin
         hold_done_q <= 1'b1;
      end else if (!hold_done_q) begin
         hold_cnt_q  <= hold_cnt_q + 32'h1;
      end
   end

   wire enter_ev = rise[0] | long_ds;
   wire disp_ev  = rise[1];
   wire tog_ev   = rise[2];

   // Registers
   reg [7:0]  fn_q;
   reg        pw_set_q;
   reg [3:0]  assign_digit_q;
   reg [3:0]  dir_digit_q;
   reg        clear_req_q;
   reg [`SAJC_IRQ_W-1:0] irq_st_q;
   reg [`SAJC_IRQ_W-1:0] irq_mask_q;
   reg [2:0]  state_q;
   reg [3:0]  view_q;
   reg [31:0] flash_cnt_q;

   // History storage; presetn clears every entry, software rewrites entries through the retain window
   // Entry i sits in byte i; each byte has its own flop set, so no shared driver
   wire [8*`SAJC_HIST_DEPTH-1:0] hist_flat;
   reg  [3:0]                    hcount_q;

   wire        wr_acc  = psel && penable && pwrite;
   wire        rd_acc  = psel && penable && !pwrite;
   wire        in_ret  = (paddr >= `SAJC_A_RETAIN_BASE) && (paddr <= `SAJC_A_RETAIN_TOP) && (paddr[1:0] == 2'b00);
   wire [3:0]  ret_idx = paddr[5:2] - 4'h0;
   wire        mapped  = (paddr == `SAJC_A_CTRL) || (paddr == `SAJC_A_STATUS) || (paddr == `SAJC_A_JOGSPD) ||
                         (paddr == `SAJC_A_CFG) || (paddr == `SAJC_A_HSEL) || (paddr == `SAJC_A_HDATA) ||
                         (paddr == `SAJC_A_IRQ_ST) || (paddr == `SAJC_A_IRQ_MASK) || in_ret;
   wire        prot_wr = wr_acc && pw_set_q && ((paddr == `SAJC_A_JOGSPD) || (paddr == `SAJC_A_CFG));
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   wire ctrl_wr = wr_acc && (paddr == `SAJC_A_CTRL);
   wire pw_fn   = ctrl_wr && pwdata[0] && (pwdata[15:8] == `SAJC_FN_PASSWORD);
   wire clr_fn  = ctrl_wr && pwdata[0] && (pwdata[15:8] == `SAJC_FN_CLEAR);
   wire clr_go  = clr_fn && !pw_set_q;

   // Alarm capture
   wire alarm_new = alarm_valid && !alarm_from_operator;
   wire dup       = (hcount_q != 4'h0) && (hist_flat[7:0] == alarm_code);
   wire push      = alarm_new && !dup && !clr_go;

   genvar gi;
   generate
      for (gi = 0; gi < `SAJC_HIST_DEPTH; gi = gi + 1) begin : g_hist
         localparam [3:0] IDX = gi;
         reg  [7:0] entry_q;
         wire [7:0] older_in;
         if (gi == 0) begin : g_head
            assign older_in = alarm_code;
         end else begin : g_tail
            // Oldest byte simply falls off the end
            assign older_in = hist_flat[8*gi-1 -: 8];
         end
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               entry_q <= `SAJC_NONE_CODE;
            end else if (clr_go) begin
               entry_q <= `SAJC_NONE_CODE;
            end else if (wr_acc && in_ret && ret_idx == IDX) begin
               entry_q <= pwdata[7:0];
            end else if (push) begin
               entry_q <= older_in;
            end
         end
         assign hist_flat[8*gi+7 -: 8] = entry_q;
      end
   endgenerate

   // Entry count; the retained image restore also restores the count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcount_q <= 4'h0;
      end else if (clr_go) begin
         hcount_q <= 4'h0;
      end else if (wr_acc && paddr == `SAJC_A_HSEL && pwdata[31]) begin
         hcount_q <= (pwdata[27:24] > `SAJC_SEQ_MAX) ? `SAJC_HIST_FULL : pwdata[27:24];
      end else if (push && hcount_q != `SAJC_HIST_FULL) begin
         hcount_q <= hcount_q + 4'h1;
      end
   end

   // Alarm condition; reset touches nothing in the history
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         alarm_active <= 1'b0;
      else if (alarm_valid)
         alarm_active <= 1'b1;
      else if (alarm_reset)
         alarm_active <= 1'b0;
   end

   wire jog_block = son_s || (assign_digit_q == `SAJC_FORCE_ON_DIGIT);
   wire refuse_ev = (state_q == S_MENU) && enter_ev && fn_q == `SAJC_FN_JOG && jog_block;
   wire flash_ev  = prot_wr || (clr_fn && pw_set_q);
   // Long hold with power on only drops power, so it is no exit
   wire jog_exit  = (state_q == S_JOG) && (disp_ev || (long_ds && !motor_power));

   // Mode sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= S_MENU;
         view_q      <= 4'h0;
         motor_power <= 1'b0;
      end else begin
         case (state_q)
            S_MENU: begin
               motor_power <= 1'b0;
               if (enter_ev && fn_q == `SAJC_FN_HISTORY) begin
                  state_q <= S_HIST;
                  view_q  <= 4'h0;
               end else if (enter_ev && fn_q == `SAJC_FN_JOG && !jog_block) begin
                  state_q <= S_JOG;
               end
            end
            S_HIST: begin
               if (enter_ev || disp_ev)
                  state_q <= S_MENU;
               else if (rise[5] && view_q != 4'h0)
                  view_q <= view_q - 4'h1;
               else if (rise[4] && view_q < `SAJC_SEQ_MAX && view_q + 4'h1 < hcount_q)
                  view_q <= view_q + 4'h1;
            end
            S_JOG: begin
               if (disp_ev) begin
                  motor_power <= 1'b0;
                  state_q     <= S_MENU;
               end else if (long_ds) begin
                  if (motor_power)
                     motor_power <= 1'b0;
                  else
                     state_q <= S_MENU;
               end else if (tog_ev) begin
                  motor_power <= ~motor_power;
               end
            end
            default: begin
               state_q     <= S_MENU;
               motor_power <= 1'b0;
            end
         endcase
      end
   end

   // Motion outputs registered from held keys
   // Any event that drops power also stops motion in the same edge
   wire run    = (state_q == S_JOG) && motor_power && !disp_ev && !long_ds && !tog_ev;
   wire rev_sw = (dir_digit_q != `SAJC_DIR_RST);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_fwd   <= 1'b0;
         motor_rev   <= 1'b0;
         menu_active <= 1'b1;
      end else begin
         motor_fwd   <= run && (up_s ^ dn_s) && (up_s ^ rev_sw);
         motor_rev   <= run && (up_s ^ dn_s) && (dn_s ^ rev_sw);
         menu_active <= (state_q == S_MENU);
      end
   end

   // Software side registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fn_q           <= `SAJC_FN_HISTORY;
         pw_set_q       <= 1'b0;
         assign_digit_q <= 4'h0;
         dir_digit_q    <= `SAJC_DIR_RST;
         jog_speed      <= `SAJC_JOG_SPEED_RST;
         irq_mask_q     <= {`SAJC_IRQ_W{1'b0}};
         clear_req_q    <= 1'b0;
      end else begin
         clear_req_q <= clr_go;
         if (ctrl_wr) begin
            fn_q <= pwdata[15:8];
            if (pw_fn)
               pw_set_q <= pwdata[1];
         end
         if (wr_acc && paddr == `SAJC_A_JOGSPD && !pw_set_q)
            jog_speed <= pwdata[15:0];
         if (wr_acc && paddr == `SAJC_A_CFG && !pw_set_q) begin
            assign_digit_q <= pwdata[7:4];
            dir_digit_q    <= pwdata[3:0];
         end
         if (wr_acc && paddr == `SAJC_A_IRQ_MASK)
            irq_mask_q <= pwdata[`SAJC_IRQ_W-1:0];
      end
   end

   // Protection flash lasts one second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cnt_q   <= 32'h0;
         protect_flash <= 1'b0;
      end else if (flash_ev) begin
         flash_cnt_q   <= HOLD_LIM;
         protect_flash <= 1'b1;
      end else if (flash_cnt_q != 32'h0) begin
         flash_cnt_q <= flash_cnt_q - 32'h1;
      end else begin
         protect_flash <= 1'b0;
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   wire [`SAJC_IRQ_W-1:0] ev = {jog_exit, flash_ev, refuse_ev, push};
   wire [`SAJC_IRQ_W-1:0] w1c = (wr_acc && paddr == `SAJC_A_IRQ_ST) ? pwdata[`SAJC_IRQ_W-1:0]
                                                                   : {`SAJC_IRQ_W{1'b0}};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_st_q <= {`SAJC_IRQ_W{1'b0}};
      else
         irq_st_q <= (irq_st_q & ~w1c) | ev;
   end
   assign irq = |(irq_st_q & irq_mask_q);

   // Read mux
   wire [3:0] hsel = view_q;
   always @* begin
      prdata = 32'h0;
      if (rd_acc) begin
         if (in_ret && ret_idx < `SAJC_HIST_FULL)
            prdata = {24'h0, hist_flat[{ret_idx, 3'b000} +: 8]};
         else case (paddr)
            `SAJC_A_CTRL:     prdata = {16'h0, fn_q, 6'h0, pw_set_q, 1'b0};
            `SAJC_A_STATUS:   prdata = {22'h0, jog_block, protect_flash, alarm_active, motor_rev, motor_fwd,
                                        motor_power, state_q, clear_req_q};
            `SAJC_A_JOGSPD:   prdata = {16'h0, jog_speed};
            `SAJC_A_CFG:      prdata = {24'h0, assign_digit_q, dir_digit_q};
            `SAJC_A_HSEL:     prdata = {4'h0, hcount_q, 20'h0, hsel};
            `SAJC_A_HDATA:    prdata = {20'h0, hsel,
                                        (hsel < hcount_q) ? hist_flat[{hsel, 3'b000} +: 8] : `SAJC_NONE_CODE};
            `SAJC_A_IRQ_ST:   prdata = {28'h0, irq_st_q};
            `SAJC_A_IRQ_MASK: prdata = {28'h0, irq_mask_q};
            default:          prdata = 32'h0;
         endcase
      end
   end

endmodule

/* verilog/sajc_defs.vh */
// Constants for the servo auxiliary, alarm history and jog control block
`ifndef SAJC_DEFS_VH
`define SAJC_DEFS_VH

`define SAJC_CLK_HZ          100000000
`define SAJC_HOLD_MS         1000
`define SAJC_HIST_DEPTH      10
`define SAJC_SEQ_MAX         4'h9
`define SAJC_HIST_FULL       4'ha
`define SAJC_CODE_W          8
`define SAJC_NONE_CODE       8'h00
`define SAJC_FN_HISTORY      8'h00
`define SAJC_FN_JOG          8'h02
`define SAJC_FN_CLEAR        8'h06
`define SAJC_FN_PASSWORD     8'h10
`define SAJC_FORCE_ON_DIGIT  4'h7
`define SAJC_JOG_SPEED_RST   16'h01f4
`define SAJC_DIR_RST         4'h0

`define SAJC_A_CTRL          12'h000
`define SAJC_A_STATUS        12'h004
`define SAJC_A_JOGSPD        12'h008
`define SAJC_A_CFG           12'h00c
`define SAJC_A_HSEL          12'h010
`define SAJC_A_HDATA         12'h014
`define SAJC_A_IRQ_ST        12'h018
`define SAJC_A_IRQ_MASK      12'h01c
`define SAJC_A_RETAIN_BASE   12'h040
`define SAJC_A_RETAIN_TOP    12'h064

// Interrupt status bits
`define SAJC_IRQ_W           4
`define SAJC_IRQ_ALARM       0
`define SAJC_IRQ_REFUSE      1
`define SAJC_IRQ_PROTECT     2
`define SAJC_IRQ_JOGEXIT     3

`endif

/* bench/sajc_control_properties.sv */
// Port-level checker for the operator control block
`timescale 1ns/1ps
module sajc_control_chk (
   input logic        pclk,
   input logic        presetn,
   input logic        key_up,
   input logic        key_down,
   input logic        handheld_display_key,
   input logic        alarm_valid,
   input logic        alarm_reset,
   input logic        alarm_active,
   input logic        motor_power,
   input logic        motor_fwd,
   input logic        motor_rev,
   input logic [15:0] jog_speed,
   input logic        protect_flash,
   input logic        menu_active
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   one_dir_a: assert property (!(motor_fwd && motor_rev)) else $error("both directions driven");
   move_powered_a: assert property (motor_fwd || motor_rev |-> motor_power) else $error("motion unpowered");
   stop_release_a: assert property ((!key_up && !key_down)[*4] |=> !motor_fwd && !motor_rev)
      else $error("motion without key");
   exit_off_a: assert property ($rose(handheld_display_key) |-> ##[1:6] !motor_power)
      else $error("power kept after exit");
   power_jog_a: assert property (motor_power |-> !menu_active) else $error("power on in menu");
   alarm_set_a: assert property (alarm_valid |=> alarm_active) else $error("alarm not raised");
   reset_clr_a: assert property (alarm_reset && !alarm_valid |=> !alarm_active)
      else $error("alarm not cleared");
   flash_len_a: assert property ($rose(protect_flash) |-> protect_flash[*8] ##[1:30] !protect_flash)
      else $error("flash length wrong");
   speed_dflt_a: assert property ($rose(presetn) |-> jog_speed == 16'h01f4) else $error("jog speed default");
   cover property (motor_fwd);
   cover property ($rose(protect_flash));
   cover property (alarm_valid && !alarm_active);
endmodule
bind sajc_control sajc_control_chk u_chk (.pclk(pclk), .presetn(presetn), .key_up(key_up), .key_down(key_down),
   .handheld_display_key(handheld_display_key), .alarm_valid(alarm_valid), .alarm_reset(alarm_reset),
   .alarm_active(alarm_active), .motor_power(motor_power), .motor_fwd(motor_fwd), .motor_rev(motor_rev),
   .jog_speed(jog_speed), .protect_flash(protect_flash), .menu_active(menu_active));

/* bench/sajc_key_panel.sv */
// Key panel model: a person pressing and holding keys
`timescale 1ns/1ps
module sajc_key_panel (
   input  logic       pclk,
   output logic       servo_on_input,
   output logic [5:0] keys
);
   initial begin
      servo_on_input = 1'b0;
      keys = 6'h00;
   end
   // Settle gap covers the two-stage key synchroniser
   task automatic set_key(input int k, input logic v);
      @(posedge pclk);
      keys[k] <= v;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic press(input int k, input int n);
      set_key(k, 1'b1);
      repeat (n) @(posedge pclk);
      set_key(k, 1'b0);
   endtask
   task automatic set_servo(input logic v);
      @(posedge pclk);
      servo_on_input <= v;
      repeat (4) @(posedge pclk);
   endtask
endmodule

/* bench/sajc_control_tb_top.sv */
// Self-checking bench for the operator control block
`timescale 1ns/1ps
`include "sajc_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module sajc_control_tb_top;
   localparam int HOLD = 20;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdv;
   logic        pready, pslverr, last_err, servo_on, irq;
   logic        alarm_valid = 1'b0;
   logic [7:0]  alarm_code = 8'h00;
   logic        alarm_op = 1'b0;
   logic        alarm_reset = 1'b0;
   logic        alarm_active, motor_power, motor_fwd, motor_rev, protect_flash, menu_active;
   logic [15:0] jog_speed, v;
   logic [5:0]  keys;
   logic [7:0]  hist[$];
   int          n_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   always #5 pclk = ~pclk;
   sajc_key_panel p (.pclk(pclk), .servo_on_input(servo_on), .keys(keys));
   sajc_control #(.HOLD_CYCLES(HOLD)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .servo_on_input(servo_on), .key_up(keys[0]), .key_down(keys[1]), .key_data_shift(keys[2]),
      .servo_toggle_key(keys[3]), .handheld_display_key(keys[4]), .handheld_enter_key(keys[5]),
      .alarm_valid(alarm_valid), .alarm_code(alarm_code), .alarm_from_operator(alarm_op),
      .alarm_reset(alarm_reset), .alarm_active(alarm_active), .motor_power(motor_power), .motor_fwd(motor_fwd),
      .motor_rev(motor_rev), .jog_speed(jog_speed), .protect_flash(protect_flash), .menu_active(menu_active),
      .irq(irq));
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Model: newest first, duplicates of newest and panel alarms dropped
   task automatic alarm(input logic [7:0] c, input logic op);
      @(posedge pclk);
      alarm_valid <= 1'b1;
      alarm_code <= c;
      alarm_op <= op;
      @(posedge pclk);
      alarm_valid <= 1'b0;
      @(negedge pclk);
      if (!op && (hist.size() == 0 || hist[0] != c)) hist.push_front(c);
      if (hist.size() > 10) void'(hist.pop_back());
   endtask
   task automatic chk_hist();
      apb(1'b0, `SAJC_A_HSEL, 32'h0);
      `CHK("count", 4'(hist.size()), rdv[27:24])
      foreach (hist[i]) begin
         apb(1'b0, 12'(`SAJC_A_RETAIN_BASE + 4 * i), 32'h0);
         `CHK("entry", hist[i], rdv[7:0])
      end
   endtask
   task automatic chk_state(input logic [2:0] e);
      apb(1'b0, `SAJC_A_STATUS, 32'h0);
      `CHK("state", e, rdv[3:1])
   endtask
   function automatic logic [1:0] exp_mot(input logic up, input logic [3:0] dir);
      return (up ^ (dir != 4'h0)) ? 2'b10 : 2'b01;
   endfunction
   initial begin
      void'($urandom(32'h14b5));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SAJC_A_JOGSPD, 32'h0);
      `CHK("jog speed", 32'h1f4, rdv)
      apb(1'b0, `SAJC_A_CFG, 32'h0);
      `CHK("cfg", 32'h0, rdv)
      apb(1'b0, 12'h100, 32'h0);
      `CHK("unmapped", 1'b1, last_err)
      $display("registers test done");
      apb(1'b1, `SAJC_A_IRQ_MASK, 32'h1);
      for (int i = 0; i < 12; i++) alarm(8'($urandom_range(1, 255)), 1'b0);
      alarm(hist[0], 1'b0);
      alarm(8'($urandom_range(1, 255)), 1'b1);
      chk_hist();
      `CHK("irq", 1'b1, irq)
      apb(1'b1, `SAJC_A_IRQ_ST, 32'hf);
      @(negedge pclk);
      `CHK("irq clear", 1'b0, irq)
      @(posedge pclk);
      alarm_reset <= 1'b1;
      @(posedge pclk);
      alarm_reset <= 1'b0;
      @(negedge pclk);
      `CHK("alarm reset", 1'b0, alarm_active)
      apb(1'b1, `SAJC_A_RETAIN_BASE, 32'h5a);
      hist[0] = 8'h5a;
      chk_hist();
      apb(1'b1, `SAJC_A_CTRL, 32'h0);
      p.press(5, 2);
      chk_state(3'b010);
      p.press(1, 2);
      p.press(1, 2);
      p.press(0, 2);
      apb(1'b0, `SAJC_A_HSEL, 32'h0);
      `CHK("view seq", 4'h1, rdv[3:0])
      apb(1'b0, `SAJC_A_HDATA, 32'h0);
      `CHK("view code", {4'h1, hist[1]}, rdv[11:0])
      p.press(4, 2);
      apb(1'b1, `SAJC_A_CTRL, 32'h0601);
      hist.delete();
      chk_hist();
      $display("history test done");
      apb(1'b1, `SAJC_A_CTRL, 32'h0200);
      p.set_servo(1'b1);
      p.press(2, HOLD + 4);
      chk_state(3'b001);
      p.set_servo(1'b0);
      apb(1'b1, `SAJC_A_CFG, 32'h70);
      p.press(2, HOLD + 4);
      chk_state(3'b001);
      apb(1'b1, `SAJC_A_CFG, 32'h0);
      p.press(2, 5);
      chk_state(3'b001);
      p.press(2, HOLD + 4);
      chk_state(3'b100);
      for (int d = 0; d < 2; d++) begin
         apb(1'b1, `SAJC_A_CFG, 32'(d));
         p.press(3, 2);
         `CHK("power on", 1'b1, motor_power)
         for (int u = 0; u < 2; u++) begin
            p.set_key(u, 1'b1);
            `CHK("motion", exp_mot(u == 0, 4'(d)), {motor_fwd, motor_rev})
            p.set_key(u, 1'b0);
            `CHK("stop", 2'b00, {motor_fwd, motor_rev})
         end
         if (d == 0) p.press(3, 2);
         else p.press(2, HOLD + 4);
         `CHK("power off", 1'b0, motor_power)
      end
      p.press(3, 2);
      p.press(4, 2);
      `CHK("exit", 2'b01, {motor_power, menu_active})
      p.press(5, 2);
      chk_state(3'b100);
      p.press(2, HOLD + 4);
      `CHK("long exit", 1'b1, menu_active)
      $display("jog test done");
      apb(1'b1, `SAJC_A_CTRL, 32'h1003);
      apb(1'b1, `SAJC_A_JOGSPD, 32'h3e8);
      @(negedge pclk);
      `CHK("flash", 1'b1, protect_flash)
      apb(1'b0, `SAJC_A_JOGSPD, 32'h0);
      `CHK("protected", 32'h1f4, rdv)
      alarm(8'h3c, 1'b0);
      apb(1'b1, `SAJC_A_CTRL, 32'h0601);
      chk_hist();
      apb(1'b0, `SAJC_A_IRQ_ST, 32'h0);
      `CHK("irq status", 4'hf, rdv[3:0])
      apb(1'b1, `SAJC_A_CTRL, 32'h1001);
      v = 16'($urandom_range(1, 6000));
      apb(1'b1, `SAJC_A_JOGSPD, {16'h0, v});
      @(negedge pclk);
      `CHK("speed out", v, jog_speed)
      $display("password test done");
      stop_test();
   end
endmodule
